// ==== bench/testbench.sv ====
// Self-checking bench for the converter config and result register bank
`timescale 1ns/1ps
module testbench;
   logic                    core_clk;
   logic                    rst_n;
   adcr_pkg::adcr_apb_req_t req;
   logic [31:0]             prdata;
   logic                    pready;
   logic                    pslverr;
   logic [23:0]             convVal;
   logic                    convDone;
   adcr_pkg::adcr_ctrl_t    ctrl;
   logic signed [7:0]       driftPpm;
   logic [6:0]              sumTotal;
   adcr_pkg::adcr_ref_t     refSrc;
   logic [8:0]              regMv10;
   int                      err_count;
   int                      checks_done;
   logic [31:0]             rd;
   logic [7:0]              v;
   adcr_pkg::adcr_ref_t     expRef;
   logic [8:0]              mvTab [4] = '{9'd235, 9'd245, 9'd280, 9'd300};
   logic signed [7:0]       coefTab [8] = '{0, -1, -2, -3, 0, 1, 2, 3};

   adcr_config_result_regs uut (
      .core_clk             (core_clk),
      .rst_n                (rst_n),
      .apbReq               (req),
      .prdata               (prdata),
      .pready               (pready),
      .pslverr              (pslverr),
      .conversionValue      (convVal),
      .conversionDone       (convDone),
      .ctrl                 (ctrl),
      .driftPpmScaled       (driftPpm),
      .decimatorSumTotal    (sumTotal),
      .refSource            (refSrc),
      .regulatorMillivolt10 (regMv10)
   );

   // ----------------------------------------
   // Clock and watchdog
   // ----------------------------------------
   initial begin
      core_clk = 1'b0;
      forever #5 core_clk = ~core_clk;
   end

   // Whole run is a few hundred cycles; 100 us leaves wide margin
   initial begin
      #100us;
      err_count++;
      finish_test();
   end

   // ----------------------------------------
   // Bus tasks and comparison
   // ----------------------------------------
   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
      checks_done++;
      if (got !== exp) begin
         err_count++;
         $display("ERROR t=%0t %s got=%h exp=%h", $time, what, got, exp);
      end
   endtask : chk

   // Read data is taken at the edge where ready is seen high
   task automatic apb_xfer(input logic wr, input logic [11:0] a, input logic [31:0] d,
                           output logic [31:0] q);
      @(posedge core_clk);
      req <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: a, pwdata: d};
      @(posedge core_clk);
      req.penable <= 1'b1;
      // Values read here are those the slave shows at this edge
      do @(posedge core_clk); while (pready !== 1'b1);
      q = prdata;
      req <= '0;
   endtask : apb_xfer

   task automatic apb_write(input logic [11:0] a, input logic [31:0] d);
      logic [31:0] dummy;
      apb_xfer(1'b1, a, d, dummy);
      // One more edge so the stored byte reaches the decoded outputs
      @(posedge core_clk);
   endtask : apb_write

   task automatic apb_read(input logic [11:0] a, output logic [31:0] q);
      apb_xfer(1'b0, a, 32'h0, q);
   endtask : apb_read

   task automatic finish_test();
      $display("checks=%0d errors=%0d", checks_done, err_count);
      if (err_count == 0 && checks_done > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask : finish_test

   // ----------------------------------------
   // Test sequence
   // ----------------------------------------
   initial begin
      err_count = 0;
      checks_done = 0;
      rst_n = 1'b0;
      req = '0;
      convVal = 24'h0;
      convDone = 1'b0;
      repeat (4) @(posedge core_clk);
      rst_n <= 1'b1;

      apb_read(12'h010, rd); chk(rd, 32'h0, "drift rst");
      apb_read(12'h014, rd); chk(rd, 32'h40, "chop rst");
      apb_read(12'h018, rd); chk(rd, 32'h0, "filter rst");
      apb_read(12'h024, rd); chk(rd, 32'h0, "result rst");
      $display("reset test done");

      // Bits 1:0 written as ones must read back zero
      for (int i = 0; i < 16; i++) begin
         v = {i[3], i[2:0], 4'hF};
         apb_write(12'h010, {24'h0, v});
         apb_read(12'h010, rd); chk(rd, {24'h0, v[7:4], 4'hC}, "drift rb");
         chk({24'h0, driftPpm}, {24'h0, 8'(coefTab[i[2:0]] * (i[3] ? 6 : 1))}, "ppm");
         chk({29'h0, ctrl.driftCoefficient}, {29'h0, i[2:0]}, "coef");
         chk({31'h0, ctrl.driftStepCoarse}, {31'h0, i[3]}, "coarse");
      end
      apb_write(12'h010, 32'h08);
      chk({31'h0, ctrl.shifterChopActive}, 32'h0, "chop no shift");
      apb_write(12'h010, 32'h0C);
      chk({31'h0, ctrl.shifterChopActive}, 32'h1, "chop shift");
      chk({31'h0, ctrl.inputShifterEnable}, 32'h1, "shift en");
      $display("drift test done");

      for (int i = 0; i < 4; i++) begin
         v = {i[1:0], i[1:0], i[1:0], i[1:0]};
         expRef = i[1] ? adcr_pkg::REF_INTERNAL_GROUND :
                  (i == 1) ? adcr_pkg::REF_INTERNAL_LOOPBACK : adcr_pkg::REF_EXTERNAL_BOTH;
         // Output rate lives outside this bank; each pass sets chop, sum, reference and regulator codes alike
         apb_write(12'h014, {24'h0, v});
         apb_read(12'h014, rd); chk(rd, {24'h0, v}, "chop rb");
         chk({30'h0, ctrl.ampModulatorChopRate}, {30'h0, i[1:0]}, "chop");
         chk({25'h0, sumTotal}, 32'd8 << i, "sum count");
         chk({30'h0, refSrc}, {30'h0, expRef}, "ref");
         chk({23'h0, regMv10}, {23'h0, mvTab[i]}, "ldo");
      end
      $display("chop test done");

      // Mode and rate live elsewhere; low-pass is only a stored bit here
      apb_write(12'h018, 32'hFF);
      apb_read(12'h018, rd); chk(rd, 32'h17, "filter rb");
      chk({28'h0, ctrl.externalRcFilterEnable, ctrl.postDecimatorLowpassEnable,
           ctrl.filterNoncascadeSelect, ctrl.filterCoefficientSelect}, 32'hF, "flt1");
      apb_write(12'h018, 32'h05);
      chk({28'h0, ctrl.externalRcFilterEnable, ctrl.postDecimatorLowpassEnable,
           ctrl.filterNoncascadeSelect, ctrl.filterCoefficientSelect}, 32'h5, "flt2");
      $display("filter test done");

      @(posedge core_clk);
      convVal <= 24'hA5C3F1;
      convDone <= 1'b1;
      @(posedge core_clk);
      convDone <= 1'b0;
      convVal <= 24'h123456;
      apb_read(12'h024, rd); chk(rd, 32'hA5C3F1, "result");
      apb_write(12'h024, 32'hFFFFFF);
      apb_read(12'h024, rd); chk(rd, 32'hA5C3F1, "result ro");
      apb_read(12'h01C, rd); chk(rd, 32'h0, "unmapped");
      apb_read(12'h011, rd); chk(rd, 32'h0, "misaligned");
      chk({31'h0, pslverr}, 32'h0, "slverr");
      $display("result test done");
      finish_test();
   end
endmodule : testbench

// ==== common/adcr_pkg.sv ====
// Register offsets, field layouts and reset values for the converter config and result bank
package adcr_pkg;

   // Register indices as printed; byte address is four times the index
   localparam logic [7:0] DRIFT_COMP_LEVEL_SHIFT_CFG_IDX   = 8'h04;
   localparam logic [7:0] CHOP_ACCUM_REF_REGULATOR_CFG_IDX = 8'h05;
   localparam logic [7:0] LOWPASS_FILTER_CFG_IDX           = 8'h06;
   localparam logic [7:0] CONVERSION_RESULT_IDX            = 8'h09;

   // Field positions
   localparam int DRIFT_STEP_POS      = 7;
   localparam int DRIFT_COEF_LSB      = 4;
   localparam int SHIFTER_CHOP_POS    = 3;
   localparam int SHIFTER_EN_POS      = 2;
   localparam int CHOP_RATE_LSB       = 6;
   localparam int SUM_COUNT_LSB       = 4;
   localparam int REF_SEL_LSB         = 2;
   localparam int REG_SEL_LSB         = 0;
   localparam int EXT_RC_POS          = 4;
   localparam int LPF_EN_POS          = 2;
   localparam int LPF_NONCASC_POS     = 1;
   localparam int LPF_COEF_POS        = 0;

   // Reset values
   localparam logic [7:0]  DRIFT_CFG_RST  = 8'h00;
   localparam logic [7:0]  CHOP_CFG_RST   = 8'h40;
   localparam logic [7:0]  FILTER_CFG_RST = 8'h00;
   localparam logic [23:0] RESULT_RST     = 24'h000000;

   // Writable bit masks; unused and reserved bits read zero
   localparam logic [7:0] DRIFT_CFG_MASK  = 8'hFC;
   localparam logic [7:0] CHOP_CFG_MASK   = 8'hFF;
   localparam logic [7:0] FILTER_CFG_MASK = 8'h17;

   // Coarse step multiplier
   localparam int COARSE_STEP_FACTOR = 6;

   typedef struct packed {
      logic        psel;
      logic        penable;
      logic        pwrite;
      logic [11:0] paddr;
      logic [31:0] pwdata;
   } adcr_apb_req_t;

   typedef struct packed {
      logic        driftStepCoarse;
      logic [2:0]  driftCoefficient;
      logic        shifterChopActive;
      logic        inputShifterEnable;
      logic [1:0]  ampModulatorChopRate;
      logic [1:0]  decimatorSumCount;
      logic [1:0]  referenceSourceSelect;
      logic [1:0]  regulatorVoltageSelect;
      logic        externalRcFilterEnable;
      logic        postDecimatorLowpassEnable;
      logic        filterNoncascadeSelect;
      logic        filterCoefficientSelect;
   } adcr_ctrl_t;

   typedef enum logic [1:0] {
      REF_EXTERNAL_BOTH,
      REF_INTERNAL_LOOPBACK,
      REF_INTERNAL_GROUND
   } adcr_ref_t;

endpackage : adcr_pkg

// ==== logic/adcr_config_result_regs.sv ====
// APB register bank: drift, shifter, chop, reference, regulator, filter settings and result
//
// The APB register port is this design's own decision.
`timescale 1ns/1ps

module adcr_config_result_regs (
   input  wire logic                 core_clk,      // System clock, 100 MHz
   input  wire logic                 rst_n,         // Synchronous reset, active low
   input  wire adcr_pkg::adcr_apb_req_t apbReq,     // APB request group
   output logic      [31:0]          prdata,        // APB read data
   output logic                      pready,        // APB ready
   output logic                      pslverr,       // APB error, always driven low
   input  wire logic [23:0]          conversionValue, // New result from decimator
   input  wire logic                 conversionDone,  // One-cycle pulse, result valid
   output adcr_pkg::adcr_ctrl_t      ctrl,          // Decoded settings to analog side
   output logic signed [7:0]         driftPpmScaled, // Drift in 5 ppm units, times step
   output logic      [6:0]           decimatorSumTotal, // Number of summed outputs
   output adcr_pkg::adcr_ref_t       refSource,     // Decoded reference routing
   output logic      [8:0]           regulatorMillivolt10 // Supply setting in 10 mV units
);

   // ----------------------------------------------------------------
   // Bus decode
   // ----------------------------------------------------------------
   logic [7:0]  driftCfg_q, driftCfg_d;
   logic [7:0]  chopCfg_q, chopCfg_d;
   logic [7:0]  filterCfg_q, filterCfg_d;
   logic [23:0] result_q, result_d;

   wire logic        wordAligned = (apbReq.paddr[1:0] == 2'h0);
   wire logic [9:0]  regIndex    = apbReq.paddr[11:2];
   wire logic        selDrift    = wordAligned &&
      (regIndex == {2'h0, adcr_pkg::DRIFT_COMP_LEVEL_SHIFT_CFG_IDX});
   wire logic        selChop     = wordAligned &&
      (regIndex == {2'h0, adcr_pkg::CHOP_ACCUM_REF_REGULATOR_CFG_IDX});
   wire logic        selFilter   = wordAligned &&
      (regIndex == {2'h0, adcr_pkg::LOWPASS_FILTER_CFG_IDX});
   wire logic        selResult   = wordAligned &&
      (regIndex == {2'h0, adcr_pkg::CONVERSION_RESULT_IDX});
   wire logic        mapped      = selDrift | selChop | selFilter | selResult;
   wire logic        access      = apbReq.psel & apbReq.penable;
   wire logic        wrEn        = access & apbReq.pwrite & mapped;
   wire logic        rdEn        = access & ~apbReq.pwrite & mapped;
   // Result is read-only; a write to it sets badAccess but never raises pslverr
   wire logic        badAccess   = access & (~mapped | (apbReq.pwrite & selResult));

   wire logic [31:0] readMux =
      selDrift  ? {24'h000000, driftCfg_q}  :
      selChop   ? {24'h000000, chopCfg_q}   :
      selFilter ? {24'h000000, filterCfg_q} :
      selResult ? {8'h00, result_q}         : 32'h00000000;

   // Reads take one wait state so the registered word already stands
   // at the edge where the master samples ready; writes need none
   logic            rdValid_q, rdValid_d;
   wire logic       rdAccess   = access & ~apbReq.pwrite;
   assign rdValid_d = rdAccess & ~rdValid_q;
   assign pready    = ~rdAccess | rdValid_q;

   // ----------------------------------------------------------------
   // Register update
   // ----------------------------------------------------------------
   // Unused shifter-register bits masked
   assign driftCfg_d  = (wrEn && selDrift) ?
      (apbReq.pwdata[7:0] & adcr_pkg::DRIFT_CFG_MASK) : driftCfg_q;
   assign chopCfg_d   = (wrEn && selChop) ?
      (apbReq.pwdata[7:0] & adcr_pkg::CHOP_CFG_MASK) : chopCfg_q;
   assign filterCfg_d = (wrEn && selFilter) ?
      (apbReq.pwdata[7:0] & adcr_pkg::FILTER_CFG_MASK) : filterCfg_q;
   assign result_d    = conversionDone ? conversionValue : result_q;

   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         driftCfg_q  <= adcr_pkg::DRIFT_CFG_RST;
         chopCfg_q   <= adcr_pkg::CHOP_CFG_RST;
         filterCfg_q <= adcr_pkg::FILTER_CFG_RST;
         result_q    <= adcr_pkg::RESULT_RST;
         prdata      <= 32'h00000000;
         pslverr     <= 1'b0;
         rdValid_q   <= 1'b0;
      end else begin
         driftCfg_q  <= driftCfg_d;
         chopCfg_q   <= chopCfg_d;
         filterCfg_q <= filterCfg_d;
         result_q    <= result_d;
         prdata      <= (rdEn & ~rdValid_q) ? readMux : 32'h00000000;
         rdValid_q   <= rdValid_d;
         pslverr     <= 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // Field decode
   // ----------------------------------------------------------------
   // Registered read data costs one wait state on every read; in return
   // the word is taken at a single edge, so a conversion landing during
   // the access cannot tear the result across its bytes.
   // Decoded settings below follow the stored bytes combinationally.

   // Maps the 3-bit drift code to a signed count of 5 ppm steps
   function automatic logic signed [3:0] drift_steps(input logic [2:0] code);
      logic signed [3:0] s;
      s = 4'sh0;
      unique case (code)
         3'h7: s = 4'sh3;
         3'h6: s = 4'sh2;
         3'h5: s = 4'sh1;
         3'h4: s = 4'sh0;
         3'h0: s = 4'sh0;
         3'h1: s = -4'sh1;
         3'h2: s = -4'sh2;
         3'h3: s = -4'sh3;
      endcase
      return s;
   endfunction : drift_steps

   wire logic [2:0] driftCode = driftCfg_q[adcr_pkg::DRIFT_COEF_LSB +: 3];
   wire logic       coarse    = driftCfg_q[adcr_pkg::DRIFT_STEP_POS];
   wire logic signed [7:0] fineSteps = 8'(drift_steps(driftCode));

   assign driftPpmScaled = coarse ?
      8'(fineSteps * 8'(adcr_pkg::COARSE_STEP_FACTOR)) : fineSteps;

   assign ctrl.driftStepCoarse      = coarse;
   assign ctrl.driftCoefficient     = driftCode;
   assign ctrl.inputShifterEnable   = driftCfg_q[adcr_pkg::SHIFTER_EN_POS];
   assign ctrl.shifterChopActive    = driftCfg_q[adcr_pkg::SHIFTER_CHOP_POS] &
                                      driftCfg_q[adcr_pkg::SHIFTER_EN_POS];
   assign ctrl.ampModulatorChopRate = chopCfg_q[adcr_pkg::CHOP_RATE_LSB +: 2];
   assign ctrl.decimatorSumCount    = chopCfg_q[adcr_pkg::SUM_COUNT_LSB +: 2];
   assign ctrl.referenceSourceSelect = chopCfg_q[adcr_pkg::REF_SEL_LSB +: 2];
   assign ctrl.regulatorVoltageSelect = chopCfg_q[adcr_pkg::REG_SEL_LSB +: 2];
   assign ctrl.externalRcFilterEnable = filterCfg_q[adcr_pkg::EXT_RC_POS];
   assign ctrl.postDecimatorLowpassEnable = filterCfg_q[adcr_pkg::LPF_EN_POS];
   assign ctrl.filterNoncascadeSelect = filterCfg_q[adcr_pkg::LPF_NONCASC_POS];
   assign ctrl.filterCoefficientSelect = filterCfg_q[adcr_pkg::LPF_COEF_POS];

   // Sum count 8 shifted by code
   assign decimatorSumTotal = 7'(7'h08 << ctrl.decimatorSumCount);

   assign refSource = ctrl.referenceSourceSelect[1] ? adcr_pkg::REF_INTERNAL_GROUND :
                      ctrl.referenceSourceSelect[0] ? adcr_pkg::REF_INTERNAL_LOOPBACK :
                                                      adcr_pkg::REF_EXTERNAL_BOTH;

   assign regulatorMillivolt10 =
      (ctrl.regulatorVoltageSelect == 2'h3) ? 9'h12C :
      (ctrl.regulatorVoltageSelect == 2'h2) ? 9'h118 :
      (ctrl.regulatorVoltageSelect == 2'h1) ? 9'h0F5 : 9'h0EB;

   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   sequence s_result_write;
      wrEn && selResult;
   endsequence

   sequence s_read_first;
      rdAccess && !rdValid_q;
   endsequence

   chk_chop_reset_val: assert property (@(posedge core_clk)
      $rose(rst_n) |-> chopCfg_q[7:6] == 2'h1)
      else $error("chop rate not 01 after reset");

   chk_result_atomic: assert property (@(posedge core_clk) disable iff (!rst_n)
      conversionDone |=> result_q == $past(conversionValue))
      else $error("result not captured whole");

   chk_result_hold: assert property (@(posedge core_clk) disable iff (!rst_n)
      !conversionDone |=> $stable(result_q))
      else $error("result changed without conversion");

   chk_result_readonly: assert property (@(posedge core_clk) disable iff (!rst_n)
      s_result_write ##0 !conversionDone |=> $stable(result_q))
      else $error("result written by bus");

   chk_shift_chop_gate: assert property (@(posedge core_clk) disable iff (!rst_n)
      ctrl.shifterChopActive |-> ctrl.inputShifterEnable)
      else $error("chop active with shifter off");

   chk_unused_zero: assert property (@(posedge core_clk) disable iff (!rst_n)
      driftCfg_q[1:0] == 2'h0 && filterCfg_q[7:5] == 3'h0 && !filterCfg_q[3])
      else $error("unused bits not zero");

   chk_coarse_scale: assert property (@(posedge core_clk) disable iff (!rst_n)
      coarse && driftCode == 3'h7 |-> driftPpmScaled == 8'sd18)
      else $error("coarse step not six times fine");

   chk_drift_neg: assert property (@(posedge core_clk) disable iff (!rst_n)
      !coarse && driftCode == 3'h3 |-> driftPpmScaled == -8'sd3)
      else $error("negative drift decode wrong");

   chk_sum_count: assert property (@(posedge core_clk) disable iff (!rst_n)
      ctrl.decimatorSumCount == 2'h3 |-> decimatorSumTotal == 7'd64)
      else $error("sum count decode wrong");

   chk_filter_write: assert property (@(posedge core_clk) disable iff (!rst_n)
      wrEn && selFilter |=> ctrl.postDecimatorLowpassEnable == $past(apbReq.pwdata[2]))
      else $error("filter enable not written");

   chk_reg_volt: assert property (@(posedge core_clk) disable iff (!rst_n)
      ctrl.regulatorVoltageSelect == 2'h0 |-> regulatorMillivolt10 == 9'd235)
      else $error("regulator decode wrong");

   chk_bad_addr: assert property (@(posedge core_clk) disable iff (!rst_n)
      badAccess |=> prdata == 32'h00000000)
      else $error("unmapped read data not zero");

   chk_read_wait: assert property (@(posedge core_clk) disable iff (!rst_n)
      s_read_first |-> !pready)
      else $error("read answered before data stood");

   chk_read_ready: assert property (@(posedge core_clk) disable iff (!rst_n)
      s_read_first ##1 rdAccess |-> pready)
      else $error("read wait state not ended");

   chk_write_nowait: assert property (@(posedge core_clk) disable iff (!rst_n)
      access && apbReq.pwrite |-> pready)
      else $error("write was stalled");

   chk_prdata_idle: assert property (@(posedge core_clk) disable iff (!rst_n)
      !access |=> prdata == 32'h00000000)
      else $error("read data not zero when idle");

   chk_result_whole: assert property (@(posedge core_clk) disable iff (!rst_n)
      s_read_first ##0 selResult ##1 pready |-> prdata == {8'h00, $past(result_q)})
      else $error("result read not from one conversion");

   chk_ref_ground: assert property (@(posedge core_clk) disable iff (!rst_n)
      ctrl.referenceSourceSelect[1] |-> refSource == adcr_pkg::REF_INTERNAL_GROUND)
      else $error("internal ground reference decode wrong");

   chk_ref_loopback: assert property (@(posedge core_clk) disable iff (!rst_n)
      ctrl.referenceSourceSelect == 2'h1 |-> refSource == adcr_pkg::REF_INTERNAL_LOOPBACK)
      else $error("looped reference decode wrong");

   chk_ref_external: assert property (@(posedge core_clk) disable iff (!rst_n)
      ctrl.referenceSourceSelect == 2'h0 |-> refSource == adcr_pkg::REF_EXTERNAL_BOTH)
      else $error("external reference decode wrong");

   chk_reg_volt_top: assert property (@(posedge core_clk) disable iff (!rst_n)
      ctrl.regulatorVoltageSelect == 2'h3 |-> regulatorMillivolt10 == 9'd300)
      else $error("top regulator decode wrong");

   chk_drift_zero: assert property (@(posedge core_clk) disable iff (!rst_n)
      driftCode == 3'h4 |-> driftPpmScaled == 8'sd0)
      else $error("zero drift code not zero");

   chk_drift_fine: assert property (@(posedge core_clk) disable iff (!rst_n)
      !coarse && driftCode == 3'h5 |-> driftPpmScaled == 8'sd1)
      else $error("positive fine drift decode wrong");

   chk_sum_min: assert property (@(posedge core_clk) disable iff (!rst_n)
      ctrl.decimatorSumCount == 2'h0 |-> decimatorSumTotal == 7'd8)
      else $error("smallest sum count wrong");

   chk_ext_rc_write: assert property (@(posedge core_clk) disable iff (!rst_n)
      wrEn && selFilter |=> ctrl.externalRcFilterEnable == $past(apbReq.pwdata[4]))
      else $error("external filter bit not written");

   chk_struct_write: assert property (@(posedge core_clk) disable iff (!rst_n)
      wrEn && selFilter |=> ctrl.filterNoncascadeSelect == $past(apbReq.pwdata[1]))
      else $error("filter structure bit not written");

   chk_coef_write: assert property (@(posedge core_clk) disable iff (!rst_n)
      wrEn && selFilter |=> ctrl.filterCoefficientSelect == $past(apbReq.pwdata[0]))
      else $error("filter coefficient bit not written");

   chk_chop_write: assert property (@(posedge core_clk) disable iff (!rst_n)
      wrEn && selChop |=> ctrl.ampModulatorChopRate == $past(apbReq.pwdata[7:6]))
      else $error("chop rate not written");

   chk_shift_en_write: assert property (@(posedge core_clk) disable iff (!rst_n)
      wrEn && selDrift |=> ctrl.inputShifterEnable == $past(apbReq.pwdata[2]))
      else $error("shifter enable not written");

   chk_step_write: assert property (@(posedge core_clk) disable iff (!rst_n)
      wrEn && selDrift |=> ctrl.driftStepCoarse == $past(apbReq.pwdata[7]))
      else $error("drift step bit not written");

   chk_code_write: assert property (@(posedge core_clk) disable iff (!rst_n)
      wrEn && selDrift |=> ctrl.driftCoefficient == $past(apbReq.pwdata[6:4]))
      else $error("drift code not written");

endmodule : adcr_config_result_regs
